// File: design/a2sq_pkg.sv
// Shared constants and types for the auto-2 sequencer mode control block.
package a2sq_pkg;

	// Frame and word geometry.
	localparam int unsigned FRAME_BITS  = 16;
	localparam int unsigned RESULT_BITS = 12;
	localparam int unsigned CHAN_BITS   = 4;
	localparam int unsigned GPIO_BITS   = 4;
	localparam int unsigned FIFO_DEPTH  = 16;

	// Command word field positions.
	localparam int unsigned CMD_HI      = 15;
	localparam int unsigned CMD_LO      = 12;
	localparam int unsigned WE_POS      = 11;
	localparam int unsigned CRST_POS    = 10;
	localparam int unsigned LAST_HI     = 9;
	localparam int unsigned LAST_LO     = 6;
	localparam int unsigned RANGE_POS   = 6;
	localparam int unsigned PD_POS      = 5;
	localparam int unsigned FMT_POS     = 4;
	localparam int unsigned GPIO_HI     = 3;
	localparam int unsigned GPIO_LO     = 0;

	// Bit count of the last serial clock edge of a frame.
	localparam logic [3:0] LAST_EDGE_CNT = 4'hF;

	// Command nibble encodings, also used as the mode held by the device.
	typedef enum logic [3:0] {
		A2SQ_CMD_KEEP   = 4'h0,
		A2SQ_CMD_MANUAL = 4'h1,
		A2SQ_CMD_AUTO2  = 4'h3,
		A2SQ_CMD_PROG2  = 4'h9
	} a2sq_cmd_t;

	// Values after reset.
	localparam logic [3:0] RST_MODE      = 4'h1;
	localparam logic [3:0] RST_CHANNEL   = 4'h0;
	localparam logic [3:0] RST_LAST_CH   = 4'hF;
	localparam logic       RST_RANGE     = 1'h0;
	localparam logic       RST_PD        = 1'h0;
	localparam logic       RST_FMT       = 1'h0;
	localparam logic [3:0] RST_GPIO      = 4'h0;
	localparam logic [15:0] RST_TX_WORD  = 16'h0000;

endpackage

// File: design/a2sq_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module a2sq_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             reset,
	// Fill side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, wr_d;
	logic [AW-1:0]    rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push;
	logic             pop;

	// Honest flags come straight from the occupancy count.
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointers wrap at the depth, which need not be a power of two.
	always_comb begin
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// Pointer and count registers.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset, so it maps onto plain memory.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

endmodule

// File: design/a2sq_mode_ctrl.sv
// Auto-2 sequencer mode control: serial frame link and command decode.
`timescale 1ns/10ps
module a2sq_mode_ctrl
	import a2sq_pkg::*;
(
	// Core clock and reset.
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Serial link from the host.
	input  wire logic        serial_clk,
	input  wire logic        cs_n,
	input  wire logic        serial_in,
	output logic             serial_out,
	output logic             serial_out_oe,
	// Converter core: channel request and settings.
	output logic             conv_start,
	output logic [3:0]       conv_channel,
	output logic             range_select,
	output logic             powerdown,
	// Converter core: results into the buffer.
	input  wire logic        result_valid,
	output logic             result_ready,
	input  wire logic [3:0]  result_channel,
	input  wire logic [11:0] result_data,
	// General purpose pins.
	input  wire logic [3:0]  gpio_is_output,
	input  wire logic [3:0]  general_pin_in,
	output logic [3:0]       general_pin_out,
	output logic [3:0]       general_pin_oe,
	// Observed state.
	output logic [3:0]       mode_now,
	output logic [3:0]       last_channel
);

	// Two clock domains meet in this block. The link side runs on the
	// falling edge of serial_clk, which only moves while the host sends
	// a frame, so nothing there may wait for a later edge: each frame
	// closes on its own sixteenth falling edge and is handed over then.
	// Toward the core the hand-over is a toggle that flips once per
	// frame. The received word stays put until the next frame closes,
	// so once the toggle has passed two flip-flops the word is settled
	// and the core reads it without keeping a copy of its own.
	// The way back is the outgoing word. The core only changes it while
	// the synchronised chip select shows an idle link, so the link side
	// sees a word that stands still for the whole frame. Keeping one
	// word in a slot instead of a second buffer on the link side costs
	// nothing but a few cycles of quiet time between frames.

	// Next channel in the scan: wrap after the programmed last one.
	function automatic logic [3:0] next_channel(
		input logic [3:0] cur,
		input logic [3:0] last
	);
		next_channel = (cur == last) ? RST_CHANNEL : cur + 4'h1;
	endfunction

	// True while the held mode is the auto-2 scan; the counter only
	// runs in that mode, and entry from another mode restarts it.
	function automatic logic in_auto2(input a2sq_cmd_t mode);
		in_auto2 = (mode == A2SQ_CMD_AUTO2);
	endfunction

	// Link domain state.
	logic [3:0]  bit_cnt_q, bit_cnt_d;
	logic [14:0] rx_sh_q, rx_sh_d;
	logic [15:0] tx_sh_q, tx_sh_d;
	logic [15:0] rx_word_q, rx_word_d;
	logic        frame_tgl_q, frame_tgl_d;
	logic        cnt_rst;

	// Core domain state.
	logic        tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic        tgl_s1_d, tgl_s2_d, tgl_s3_d;
	logic        cs_n_s1_q, cs_n_s2_q;
	logic        cs_n_s1_d, cs_n_s2_d;
	logic [3:0]  pin_s1_q, pin_s2_q;
	logic [3:0]  pin_s1_d, pin_s2_d;
	logic        frame_evt;
	logic        link_idle;
	a2sq_cmd_t   mode_q, mode_d;
	logic [3:0]  ch_q, ch_d;
	logic [3:0]  last_q, last_d;
	logic        range_q, range_d;
	logic        pd_q, pd_d;
	logic        fmt_q, fmt_d;
	logic [3:0]  gpio_q, gpio_d;
	logic [15:0] tx_word_q, tx_word_d;
	logic        slot_full_q, slot_full_d;
	logic        start_q, start_d;
	logic [3:0]  cmd;
	logic        fifo_valid;
	logic        fifo_ready;
	logic [15:0] fifo_data;

	// The bit counter clears whenever chip select is high, because the
	// serial clock may stand still between frames.
	assign cnt_rst = reset || cs_n;

	// Shift in on each falling edge and close the frame on the last one.
	always_comb begin
		bit_cnt_d   = bit_cnt_q + 4'h1;
		rx_sh_d     = {rx_sh_q[13:0], serial_in};
		tx_sh_d     = {tx_sh_q[14:0], 1'b0};
		rx_word_d   = rx_word_q;
		frame_tgl_d = frame_tgl_q;
		if (bit_cnt_q == '0) begin
			tx_sh_d = {tx_word_q[14:0], 1'b0};
		end
		if (bit_cnt_q == LAST_EDGE_CNT) begin
			rx_word_d   = {rx_sh_q, serial_in};
			frame_tgl_d = !frame_tgl_q;
		end
	end

	// Bit counter, reset by chip select outside frames. A frame cut
	// short by the host therefore leaves no partial count behind, and
	// the half-shifted word is never handed to the core.
	always_ff @(negedge serial_clk or posedge cnt_rst) begin
		if (cnt_rst) begin
			bit_cnt_q <= '0;
		end else begin
			bit_cnt_q <= bit_cnt_d;
		end
	end

	// Link shift registers and the frame toggle.
	always_ff @(negedge serial_clk or posedge reset) begin
		if (reset) begin
			rx_sh_q     <= '0;
			tx_sh_q     <= RST_TX_WORD;
			rx_word_q   <= '0;
			frame_tgl_q <= 1'b0;
		end else begin
			rx_sh_q     <= rx_sh_d;
			tx_sh_q     <= tx_sh_d;
			rx_word_q   <= rx_word_d;
			frame_tgl_q <= frame_tgl_d;
		end
	end

	// The first bit must be on the wire before any clock edge, so it
	// comes straight from the held word; later bits from the shifter.
	// data returned every frame
	assign serial_out    = (bit_cnt_q == '0) ? tx_word_q[15] : tx_sh_q[15];
	assign serial_out_oe = !cs_n;

	// Next values of the toggle, select and pin synchronisers. Each
	// stage copies the one before it; the third toggle stage is only
	// for edge detection, and the first stage of every chain feeds
	// nothing but the second.
	always_comb begin
		tgl_s1_d  = frame_tgl_q;
		tgl_s2_d  = tgl_s1_q;
		tgl_s3_d  = tgl_s2_q;
		cs_n_s1_d = cs_n;
		cs_n_s2_d = cs_n_s1_q;
		pin_s1_d  = general_pin_in;
		pin_s2_d  = pin_s1_q;
	end

	// Synchroniser registers. Chip select resets to its idle level, so
	// the core does not wait for a frame that was never opened.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tgl_s1_q  <= 1'b0;
			tgl_s2_q  <= 1'b0;
			tgl_s3_q  <= 1'b0;
			cs_n_s1_q <= 1'b1;
			cs_n_s2_q <= 1'b1;
			pin_s1_q  <= '0;
			pin_s2_q  <= '0;
		end else begin
			tgl_s1_q  <= tgl_s1_d;
			tgl_s2_q  <= tgl_s2_d;
			tgl_s3_q  <= tgl_s3_d;
			cs_n_s1_q <= cs_n_s1_d;
			cs_n_s2_q <= cs_n_s2_d;
			pin_s1_q  <= pin_s1_d;
			pin_s2_q  <= pin_s2_d;
		end
	end

	// The received word is stable long before the toggle is seen here.
	assign frame_evt = tgl_s2_q ^ tgl_s3_q;
	assign cmd       = rx_word_q[CMD_HI:CMD_LO];

	// The outgoing word may only change while no frame is open, since
	// the link side reads it without a synchroniser of its own.
	assign link_idle = cs_n_s2_q;

	// Command decode at the end of each frame, then buffer draining.
	// A frame always starts a conversion and frees the out slot, even
	// when its command changes nothing, because the host has already
	// clocked out the word that the slot held. The scan counter steps
	// first and the command may then override it: entry into auto-2
	// regardless of write enable, and the counter reset bit when write enable is set, both restart the scan at channel zero.
	// Nibbles that this block does not decode behave like the keep
	// command, so a host that talks to the other modes never upsets
	// the auto-2 settings.
	always_comb begin
		mode_d      = mode_q;
		ch_d        = ch_q;
		last_d      = last_q;
		range_d     = range_q;
		pd_d        = pd_q;
		fmt_d       = fmt_q;
		gpio_d      = gpio_q;
		tx_word_d   = tx_word_q;
		slot_full_d = slot_full_q;
		start_d     = 1'b0;
		if (frame_evt) begin
			start_d     = 1'b1;
			slot_full_d = 1'b0;
			if (in_auto2(mode_q)) begin
				ch_d = next_channel(ch_q, last_q);
			end
			case (cmd)
				A2SQ_CMD_AUTO2: begin
					if (!in_auto2(mode_q)) begin
						ch_d = RST_CHANNEL;
					end
					mode_d = A2SQ_CMD_AUTO2;
					if (rx_word_q[WE_POS]) begin
						range_d = rx_word_q[RANGE_POS];
						pd_d    = rx_word_q[PD_POS];
						fmt_d   = rx_word_q[FMT_POS];
						gpio_d  = rx_word_q[GPIO_HI:GPIO_LO];
						if (rx_word_q[CRST_POS]) begin
							ch_d = RST_CHANNEL;
						end
					end
				end
				A2SQ_CMD_PROG2: begin
					last_d = rx_word_q[LAST_HI:LAST_LO];
				end
				A2SQ_CMD_KEEP: begin
					mode_d = mode_q;
				end
				default: begin
					mode_d = mode_q;
				end
			endcase
		end else if (fifo_valid && !slot_full_q && link_idle) begin
			tx_word_d   = fmt_q ? {pin_s2_q, fifo_data[11:0]} : fifo_data;
			slot_full_d = 1'b1;
		end
	end

	// Core domain settings, counter and outgoing word. Range, power-down,
	// format and pin settings keep their value until an auto-2 frame with
	// the write enable bit set replaces them.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mode_q      <= a2sq_cmd_t'(RST_MODE);
			ch_q        <= RST_CHANNEL;
			last_q      <= RST_LAST_CH;
			range_q     <= RST_RANGE;
			pd_q        <= RST_PD;
			fmt_q       <= RST_FMT;
			gpio_q      <= RST_GPIO;
			tx_word_q   <= RST_TX_WORD;
			slot_full_q <= 1'b0;
			start_q     <= 1'b0;
		end else begin
			mode_q      <= mode_d;
			ch_q        <= ch_d;
			last_q      <= last_d;
			range_q     <= range_d;
			pd_q        <= pd_d;
			fmt_q       <= fmt_d;
			gpio_q      <= gpio_d;
			tx_word_q   <= tx_word_d;
			slot_full_q <= slot_full_d;
			start_q     <= start_d;
		end
	end

	// The slot only takes a word between frames; a stalled slot backs
	// the buffer up until the converter core sees result_ready fall.
	// With the sixteen words of the buffer and the one in the slot,
	// seventeen results fit before the first frame is needed.
	// Limitation: a host that opens a frame within about three core
	// clock cycles of a load may see the first bit of the new word.
	assign fifo_ready = !slot_full_q && !frame_evt && link_idle;

	// Results wait here so a slow host never loses a conversion.
	a2sq_fifo #(
		.WIDTH(FRAME_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk      (core_clk),
		.reset    (reset),
		.in_valid (result_valid),
		.in_ready (result_ready),
		.in_data  ({result_channel, result_data}),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data (fifo_data)
	);

	// Settings toward the converter core and the pins. The pin levels
	// are driven on every pin and only the enable decides which reach
	// the outside, so a pin turned into an output later shows the
	// level that was written before.
	// levels on every pin, enable only on output pins
	assign general_pin_out = gpio_q;
	assign general_pin_oe  = gpio_is_output;
	assign conv_start      = start_q;
	assign conv_channel    = ch_q;
	assign range_select    = range_q;
	assign powerdown       = pd_q;
	assign mode_now        = mode_q;
	assign last_channel    = last_q;

endmodule

// File: sim/a2sq_mode_ctrl_asserts.sv
// Port checker for the auto-2 mode control block.
`timescale 1ns/10ps
module a2sq_mode_ctrl_asserts (
	// Clock, reset and link select.
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       cs_n,
	input wire logic       serial_out_oe,
	// Settings seen by the converter.
	input wire logic       conv_start,
	input wire logic [3:0] conv_channel,
	input wire logic       range_select,
	input wire logic       powerdown,
	// Pins and held state.
	input wire logic [3:0] gpio_is_output,
	input wire logic [3:0] general_pin_out,
	input wire logic [3:0] general_pin_oe,
	input wire logic [3:0] mode_now,
	input wire logic [3:0] last_channel
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// A frame completion is a single cycle strobe.
	sequence s_pulse;
		conv_start ##1 !conv_start;
	endsequence

	a_start_pulse: assert property ($rose(conv_start) |-> s_pulse)
		else $error("conv_start held longer than one cycle");
	a_out_enable: assert property (serial_out_oe == !cs_n)
		else $error("serial_out_oe does not follow cs_n");
	a_pin_dir: assert property (general_pin_oe == gpio_is_output)
		else $error("general_pin_oe differs from gpio_is_output");
	// range moves only at frame end.
	a_range_frame: assert property ($changed(range_select) |-> conv_start)
		else $error("range_select changed outside a frame end");
	a_pd_frame: assert property ($changed(powerdown) |-> conv_start)
		else $error("powerdown changed outside a frame end");
	// pin levels move at frame end.
	a_gpio_frame: assert property (
		$changed(general_pin_out) |-> conv_start)
		else $error("general_pin_out changed outside a frame end");
	a_chan_frame: assert property ($changed(conv_channel) |-> conv_start)
		else $error("conv_channel changed outside a frame end");
	a_mode_frame: assert property ($changed(mode_now) |-> conv_start)
		else $error("mode_now changed outside a frame end");
	// last channel moves at frame end.
	a_last_frame: assert property ($changed(last_channel) |-> conv_start)
		else $error("last_channel changed outside a frame end");
endmodule

bind a2sq_mode_ctrl a2sq_mode_ctrl_asserts u_a2sq_mode_ctrl_asserts (
	.core_clk, .reset, .cs_n, .serial_out_oe, .conv_start, .conv_channel,
	.range_select, .powerdown, .gpio_is_output, .general_pin_out,
	.general_pin_oe, .mode_now, .last_channel
);

// File: sim/a2sq_host_model.sv
// Host model that sends serial frames and captures the reply word.
`timescale 1ns/10ps
module a2sq_host_model (
	// Serial link toward the device.
	output logic      serial_clk,
	output logic      cs_n,
	output logic      serial_in,
	input  wire logic serial_out
);
	// The link clock stands still low between frames.
	initial begin
		serial_clk = 1'h0;
		cs_n = 1'h1;
		serial_in = 1'h0;
	end

	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		#3.3;
		cs_n = 1'h0;
		for (int i = 15; i >= 0; i--) begin
			serial_in = w[i];
			#60 serial_clk = 1'h1;
			r[i] = serial_out;
			#62.5 serial_clk = 1'h0;
			#2.5;
		end
		// Released data shows the inverse so a stale level never passes.
		cs_n = 1'h1;
		serial_in = ~w[0];
		#300;
	endtask
endmodule

// File: sim/a2sq_tb.sv
// Self-checking bench for the auto-2 mode control block.
`timescale 1ns/10ps
module tb;
	logic        core_clk, reset, result_valid, result_ready, ok;
	logic        serial_clk, cs_n, serial_in, serial_out, serial_out_oe;
	logic        conv_start, range_select, powerdown;
	logic [3:0]  result_channel, conv_channel, mode_now, last_channel;
	logic [3:0]  general_pin_out, general_pin_oe;
	logic [11:0] result_data;
	logic [15:0] reply, ew;
	logic [3:0]  gpio_dir;
	int          fails, samples_checked, n;
	// last channel is written first, then auto-2 is entered.
	logic [15:0] cmd [17] = '{16'h9CBF, 16'h3C45, 16'h0000, 16'h0000,
		16'h0000, 16'h307A, 16'h3833, 16'h0000, 16'h0000, 16'h3C03,
		16'h0000, 16'h5000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000};
	// Expected {mode, channel, last, pins, range, power-down, pad}.
	logic [19:0] exp_st [17] = '{20'h10200, 20'h30258, 20'h31258,
		20'h32258, 20'h30258, 20'h31258, 20'h32234, 20'h30234, 20'h31234,
		20'h30230, 20'h31230, 20'h32230, 20'h30230, 20'h31230, 20'h32230,
		20'h30230, 20'h31230};

	a2sq_mode_ctrl u_a2sq_mode_ctrl (
		.core_clk, .reset, .serial_clk, .cs_n, .serial_in, .serial_out,
		.serial_out_oe, .conv_start, .conv_channel, .range_select,
		.powerdown, .result_valid, .result_ready, .result_channel,
		.result_data, .gpio_is_output(gpio_dir), .general_pin_in(4'hA),
		.general_pin_out, .general_pin_oe, .mode_now, .last_channel
	);
	a2sq_host_model u_a2sq_host_model (
		.serial_clk, .cs_n, .serial_in, .serial_out
	);

	// Compare helper; unknown values never pass.
	task automatic chk(string nm, logic [19:0] e, logic [19:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// Single place where the run ends.
	task automatic end_sim;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic logic [19:0] st();
		return {mode_now, conv_channel, last_channel, general_pin_out,
			range_select, powerdown, 2'h0};
	endfunction

	// Core clock at 40 MHz.
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Reset, fill the buffer, then run the frame table.
	initial begin
		reset = 1'h1;
		gpio_dir = 4'hF;
		result_valid = 1'h0;
		result_channel = 4'h0;
		result_data = 12'h000;
		fails = 0;
		samples_checked = 0;
		repeat (16) @(posedge core_clk);
		#1 reset = 1'h0;
		repeat (2) @(posedge core_clk);
		#1;
		chk("reset", 20'h10F00, st());
		// Only the pins marked as outputs are driven.
		gpio_dir = 4'h5;
		@(posedge core_clk);
		#1;
		chk("pin_oe", 20'h5, {16'h0, general_pin_oe});
		gpio_dir = 4'hF;
		// Sixteen results fill the buffer and one waits in the out slot;
		// ready is read before the edge that takes the word.
		for (int i = 0; i < 17; i++) begin
			result_valid = 1'h1;
			result_channel = 4'(i);
			result_data = {8'hC0, 4'(i)};
			n = 0;
			do begin
				ok = result_ready;
				@(posedge core_clk);
				n++;
			end while (!ok && n < 20);
			if (!ok) begin
				fails++;
				$display("BAD result_ready exp 1 got 0");
				end_sim();
			end
			#1;
		end
		result_valid = 1'h0;
		@(posedge core_clk);
		#1;
		chk("full", 20'h0, {19'h0, result_ready});
		// Each frame answers with the word held in the slot, tagged by the
		// format in force when it was loaded after the previous frame.
		for (int k = 0; k < 17; k++) begin
			u_a2sq_host_model.xfer(cmd[k], reply);
			repeat (10) @(posedge core_clk);
			#1;
			chk("state", exp_st[k], st());
			ew = {(k > 6 && k < 10) ? 4'hA : 4'(k), 8'hC0, 4'(k)};
			chk("reply", {4'h0, ew}, {4'h0, reply});
		end
		chk("drained", 20'h1, {19'h0, result_ready});
		end_sim();
	end
endmodule
